//--- test/eps_far_model.sv
/*
 * Far-side model of the enhanced PWM output stage: time base with its
 * period match pulse, the active-low fault source and comparator one.
 * Assumes the bench raises fault and comparator requests on ref_clk.
 */
module eps_far_model #(
    parameter int PERIOD = 100
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic fault_req_in,
    input wire logic cmp_req_in,
    output logic period_start_out,
    output logic [9:0] count_out,
    output logic fault_n_out,
    output logic cmp_out
);
    // ==========================================================
    // Time base: wraps after the period match
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_out <= '0;
        end else if (count_out == 10'(PERIOD - 1)) begin
            count_out <= '0;
        end else begin
            count_out <= count_out + 10'h001;
        end
    end

    // Period match marks the end of one period and start of the next
    assign period_start_out = (count_out == 10'(PERIOD - 1)) && !reset_in;

    // Fault pin idles high, comparator idles low
    assign fault_n_out = !fault_req_in;
    assign cmp_out = cmp_req_in;
endmodule // eps_far_model

//--- test/tb.sv
/*
 * Self-checking bench of the enhanced PWM output stage over APB.
 * Assumes the far-side model supplies time base, fault and comparator.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 100;
    logic ref_clk_in = 0;
    logic reset_in = 1;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_v, seed = 32'h329DC46A;
    logic pready, pslverr, rd_e, pst, fault_n, cmp, fault_req = 0, cmp_req = 0;
    logic pa, pa_oe_n, pb, pb_oe_n, tb_flag;
    logic [9:0] cnt;
    int fails = 0, check_count = 0;
    logic [7:0] ra [4] = '{eps_pkg::ADDR_CTRL, eps_pkg::ADDR_STEER,
        eps_pkg::ADDR_DBRS, eps_pkg::ADDR_DUTY};
    logic [31:0] rm [4] = '{32'hFF, 32'h13, 32'hFF, 32'hFF};

    eps_output_stage eps_output_stage_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .period_start_in(pst), .timebase_count_in(cnt),
        .fault_input_in(fault_n), .comparator_one_in(cmp), .pwm_out_a_out(pa),
        .pwm_out_a_oe_n_out(pa_oe_n), .pwm_out_b_out(pb), .pwm_out_b_oe_n_out(pb_oe_n),
        .timebase_period_flag_out(tb_flag));
    eps_far_model #(.PERIOD(PER)) eps_far_model_inst (.clk_in(ref_clk_in),
        .reset_in(reset_in), .fault_req_in(fault_req), .cmp_req_in(cmp_req),
        .period_start_out(pst), .count_out(cnt), .fault_n_out(fault_n), .cmp_out(cmp));

    // ==========================================================
    // Clock and watchdog
    initial forever #5 ref_clk_in = ~ref_clk_in;
    initial begin
        #500000;
        fails++;
        summarize();
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Pin code: 0 and level when driven, 10 released, 11 not looked at
    function automatic logic [1:0] lv(logic act, logic low_pol);
        return {1'b0, act ^ low_pol};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic p1(input string n, input logic [1:0] e, input logic o, input logic oe);
        if (e == 2'b10) chk(n, 1, 32'(oe));
        else if (e != 2'b11) chk(n, 32'({e[0], 1'b0}), 32'({o, oe}));
    endtask
    task automatic pin(input logic [1:0] ea, input logic [1:0] eb);
        p1("pin_a", ea, pa, pa_oe_n);
        p1("pin_b", eb, pb, pb_oe_n);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready !== 1'b1);
        chk("apb_wait", 2, n);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        apb(0, a, 0);
        chk(n, e & m, rd_v & m);
    endtask
    // Wait for a time base count, then let that edge settle
    task automatic at(input int v);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (cnt !== 10'(v) && n < 400);
        if (cnt !== 10'(v)) chk("tb_wait", 32'(v), 32'(cnt));
        #1;
    endtask
    task automatic setup(input logic [1:0] cfg, input logic [1:0] pol, input logic [9:0] d,
        input logic [7:0] st, input logic [6:0] db);
        wr(eps_pkg::ADDR_STEER, 0);
        wr(eps_pkg::ADDR_CTRL, 32'({cfg, d[1:0], 2'b11, pol}));
        wr(eps_pkg::ADDR_DUTY, 32'(d[9:2]));
        wr(eps_pkg::ADDR_DBRS, 32'(db));
        wr(eps_pkg::ADDR_STEER, 32'(st));
        at(PER - 1);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [9:0] d;
        repeat (3) @(posedge ref_clk_in);
        reset_in <= 0;
        for (int i = 0; i < 6; i++) rdchk("reg_reset", 8'(i * 4), '1, 0);
        apb(0, 8'h18, 0);
        chk("unmapped_err", 1, 32'(rd_e));
        chk("unmapped_data", 0, rd_v);
        pin(2'b10, 2'b10);
        for (int i = 0; i < 16; i++) begin
            d = 10'(rnd());
            wr(ra[i % 4], 32'(d[7:0]));
            rdchk("reg_rw", ra[i % 4], rm[i % 4], 32'(d[7:0]));
        end
        // Steering over every polarity and every nonzero steer choice
        for (int p = 0; p < 4; p++) for (int s = 1; s < 4; s++) begin
            d = 10'(20 + rnd() % 61);
            setup(eps_pkg::CFG_SINGLE, 2'(p), d, 8'(s), 0);
            at(d / 2);
            pin(s[0] ? lv(1, p[1]) : 2'b10, s[1] ? lv(1, p[0]) : 2'b10);
            at(d + 6);
            pin(s[0] ? lv(0, p[1]) : 2'b10, s[1] ? lv(0, p[0]) : 2'b10);
        end
        wr(eps_pkg::ADDR_CTRL, 32'h08);
        at(30);
        chk("no_mode_a", 0, 32'(pa & ~pa_oe_n));
        // Half bridge, short then overlong dead band
        setup(eps_pkg::CFG_HALF, 0, 60, 0, 3);
        at(10);
        pin(lv(0, 0), 2'b11);
        at(24);
        pin(lv(1, 0), lv(0, 0));
        at(64);
        pin(lv(0, 0), lv(0, 0));
        at(84);
        pin(lv(0, 0), lv(1, 0));
        wr(eps_pkg::ADDR_DBRS, 20);
        at(PER - 1);
        at(30);
        pin(lv(0, 0), 2'b11);
        at(58);
        pin(lv(0, 0), 2'b11);
        // Duty buffer and start-up hold-off
        setup(eps_pkg::CFG_SINGLE, 0, 40, 1, 0);
        at(10);
        wr(eps_pkg::ADDR_DUTY, 20);
        at(60);
        pin(lv(0, 0), 2'b11);
        at(PER - 1);
        at(60);
        pin(lv(1, 0), 2'b11);
        wr(eps_pkg::ADDR_CTRL, 0);
        at(PER - 1);
        at(5);
        wr(eps_pkg::ADDR_CTRL, 32'h0C);
        at(30);
        chk("start_held", 0, 32'(pa & ~pa_oe_n));
        wr(eps_pkg::ADDR_STAT, 1);
        rdchk("period_flag", eps_pkg::ADDR_STAT, 1, 0);
        at(PER - 1);
        rdchk("period_flag", eps_pkg::ADDR_STAT, 1, 1);
        chk("period_flag_pin", 1, 32'(tb_flag));
        at(30);
        pin(lv(1, 0), 2'b11);
        // Steering now and at the next period
        wr(eps_pkg::ADDR_STEER, 0);
        repeat (3) @(posedge ref_clk_in);
        #1;
        pin(2'b10, 2'b11);
        wr(eps_pkg::ADDR_STEER, 32'h11);
        at(50);
        pin(2'b10, 2'b11);
        at(PER - 1);
        at(30);
        pin(lv(1, 0), 2'b11);
        wr(eps_pkg::ADDR_STEER, 32'h10);
        at(50);
        pin(lv(1, 0), 2'b11);
        at(PER - 1);
        at(30);
        pin(2'b10, 2'b11);
        wr(eps_pkg::ADDR_STEER, 1);
        // Fault shutdown for each pair state
        for (int s = 0; s < 3; s++) begin
            wr(eps_pkg::ADDR_SHDN, 32'({4'b0010, 1'(s >> 1), 1'(s), 2'b01}));
            at(PER - 1);
            at(5);
            @(posedge ref_clk_in) fault_req <= 1;
            repeat (5) @(posedge ref_clk_in);
            #1;
            pin(s == 2 ? 2'b10 : lv(s == 1, 0), 2'b10);
            wr(eps_pkg::ADDR_SHDN, 32'({4'b0010, 1'(s >> 1), 1'(s), 2'b01}));
            rdchk("flag_held", eps_pkg::ADDR_SHDN, 32'h80, 32'h80);
            @(posedge ref_clk_in) fault_req <= 0;
            repeat (5) @(posedge ref_clk_in);
            rdchk("flag_sticky", eps_pkg::ADDR_SHDN, 32'h80, 32'h80);
            wr(eps_pkg::ADDR_SHDN, 0);
            repeat (3) @(posedge ref_clk_in);
            #1;
            chk("restart_held", 0, 32'(pa & ~pa_oe_n));
            at(PER - 1);
            at(30);
            pin(lv(1, 0), 2'b11);
        end
        // Source selection and auto-restart
        @(posedge ref_clk_in) fault_req <= 1;
        repeat (5) @(posedge ref_clk_in);
        rdchk("flag_unselected", eps_pkg::ADDR_SHDN, 32'h80, 0);
        fault_req <= 0;
        wr(eps_pkg::ADDR_SHDN, 32'h10);
        @(posedge ref_clk_in) cmp_req <= 1;
        repeat (5) @(posedge ref_clk_in);
        rdchk("flag_cmp", eps_pkg::ADDR_SHDN, 32'h80, 32'h80);
        wr(eps_pkg::ADDR_DBRS, 32'h80);
        rdchk("flag_restart", eps_pkg::ADDR_SHDN, 32'h80, 32'h80);
        @(posedge ref_clk_in) cmp_req <= 0;
        repeat (6) @(posedge ref_clk_in);
        rdchk("flag_restart", eps_pkg::ADDR_SHDN, 32'h80, 0);
        wr(eps_pkg::ADDR_SHDN, 32'h80);
        rdchk("flag_soft", eps_pkg::ADDR_SHDN, 32'h80, 0);
        wr(eps_pkg::ADDR_DBRS, 0);
        wr(eps_pkg::ADDR_SHDN, 32'h80);
        rdchk("flag_soft", eps_pkg::ADDR_SHDN, 32'h80, 32'h80);
        summarize();
    end
endmodule // tb

//--- verilog/eps_output_stage.sv
/*
 * Enhanced PWM output stage: duty double buffer, base PWM, steering,
 * half-bridge dead band, auto-shutdown and auto-restart, APB registers.
 * Assumes period_start_in and timebase_count_in come from a time base
 * on ref_clk_in; fault and comparator inputs are asynchronous.
 */
// Register access over APB and the register addresses were decided locally.
//
// Behaviour
// R1: Half-bridge drives PWM on A and its complement on B.
// R2: Steering single output only when mode upper bits 11 and config 00.
// R3: Dead-band count gives delay in instruction cycles of four clocks.
// R4: Dead band delays only inactive-to-active transitions, never deactivation.
// R5: Dead band longer than duty keeps that output inactive all cycle.
// R6: Source select chooses fault low, comparator one, besides software flag.
// R7: Shutdown event sets the flag until software or auto-restart clears.
// R8: Shutdown forces each enabled pair to its chosen high, low or float.
// R9: Shutdown is level based and lasts while the source is asserted.
// R10: Software writes to the flag are ignored while shutdown persists.
// R11: After shutdown ends the waveform resumes at next period start.
// R12: Auto-restart clears the flag in hardware once the condition leaves.
// R13: Software-set flag with auto-restart clears at once, restarts next period.
// R14: Steer enables route the same PWM to A, B or both.
// R15: Software sets at least one steer enable to see single output.
// R16: Low mode bits set polarity of the steered pins.
// R17: In steering, shutdown only touches pins enabled by steering.
// R18: Steer sync zero applies a steering change right after the write.
// R19: Steer sync one defers a steering change to the next period.
// R20: Software picks polarity before enabling the pin drivers.
// R21: Period flag sets at each period start, marking a full cycle done.
// R22: Duty value double buffered, taken into active latch at period end.
// R23: After enabling, output waits for a new period to begin.
// R24: Shutdown state: 00 inactive, 01 active, 1x high impedance.
// R25: Dead-band counter reloads on each rise, counts ticks of clock over four.
module eps_output_stage (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic period_start_in,
    input wire logic [9:0] timebase_count_in,
    input wire logic fault_input_in,
    input wire logic comparator_one_in,
    output logic pwm_out_a_out,
    output logic pwm_out_a_oe_n_out,
    output logic pwm_out_b_out,
    output logic pwm_out_b_oe_n_out,
    output logic timebase_period_flag_out
);

    // ==========================================================
    // Declarations
    logic fault_meta_r, fault_sync_r, cmp_meta_r, cmp_sync_r;
    logic [7:0] ctrl_r, ctrl_nxt, dbrs_r, dbrs_nxt, duty_hi_r, duty_hi_nxt;
    logic [6:0] shctl_r, shctl_nxt;
    logic [2:0] steer_r, steer_nxt;
    logic [1:0] steer_eff_r, steer_eff_nxt;
    logic flag_r, flag_nxt, tb_r, tb_nxt, run_r, run_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [9:0] duty_act_r, duty_act_nxt, duty_buf;
    logic base_r, base_nxt;
    logic [1:0] tick_r, tick_nxt, req, req_prev_r, act_r, act_nxt;
    logic [6:0] db_cnt_r [2];
    logic [6:0] db_cnt_nxt [2];
    logic [1:0] pin_r, pin_nxt, oe_n_r, oe_n_nxt;
    logic access, wr, rd_first, mapped, cond, tick;
    logic wr_ctrl, wr_shdn, wr_steer, wr_dbrs, wr_duty, wr_stat;
    logic [7:0] rd_byte;
    eps_pkg::eps_mode_e mode;

    // ==========================================================
    // Input synchronisers for asynchronous pins
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            fault_meta_r <= 1'b1;
            fault_sync_r <= 1'b1;
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            fault_meta_r <= fault_input_in;
            fault_sync_r <= fault_meta_r;
            cmp_meta_r <= comparator_one_in;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ==========================================================
    // APB decode: one wait state, write lands on the pready edge
    assign access = psel_in & penable_in;
    assign wr = access & pwrite_in & pready_r;
    assign rd_first = access & ~pready_r;
    assign wr_ctrl = wr & (paddr_in == eps_pkg::ADDR_CTRL);
    assign wr_shdn = wr & (paddr_in == eps_pkg::ADDR_SHDN);
    assign wr_steer = wr & (paddr_in == eps_pkg::ADDR_STEER);
    assign wr_dbrs = wr & (paddr_in == eps_pkg::ADDR_DBRS);
    assign wr_duty = wr & (paddr_in == eps_pkg::ADDR_DUTY);
    assign wr_stat = wr & (paddr_in == eps_pkg::ADDR_STAT);

    // Read mux, answers and plain register writes
    always_comb begin
        mapped = 1'b1;
        unique case (paddr_in)
            eps_pkg::ADDR_CTRL: rd_byte = ctrl_r;
            eps_pkg::ADDR_SHDN: rd_byte = {flag_r, shctl_r};
            eps_pkg::ADDR_STEER: rd_byte = {3'h0, steer_r[2], 2'h0, steer_r[1:0]};
            eps_pkg::ADDR_DBRS: rd_byte = dbrs_r;
            eps_pkg::ADDR_DUTY: rd_byte = duty_hi_r;
            eps_pkg::ADDR_STAT: rd_byte = {5'h00, cond, run_r, tb_r};
            default: begin
                rd_byte = 8'h00;
                mapped = 1'b0;
            end
        endcase
        pready_nxt = rd_first;
        pslverr_nxt = rd_first & ~mapped;
        prdata_nxt = rd_first ? {24'h000000, rd_byte} : 32'h00000000;
        ctrl_nxt = wr_ctrl ? pwdata_in[7:0] : ctrl_r;
        shctl_nxt = wr_shdn ? pwdata_in[6:0] : shctl_r;
        steer_nxt = wr_steer ? {pwdata_in[eps_pkg::STEER_SYNC_BIT],
                                pwdata_in[eps_pkg::STEER_B_BIT],
                                pwdata_in[eps_pkg::STEER_A_BIT]} : steer_r;
        dbrs_nxt = wr_dbrs ? pwdata_in[7:0] : dbrs_r;
        duty_hi_nxt = wr_duty ? pwdata_in[7:0] : duty_hi_r;
        // Period flag: set wins over a write-one clear
        if (period_start_in) begin
            tb_nxt = 1'b1; // R21
        end else if (wr_stat & pwdata_in[eps_pkg::STAT_TB_BIT]) begin
            tb_nxt = 1'b0;
        end else begin
            tb_nxt = tb_r;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ctrl_r <= eps_pkg::REG_RST;
            shctl_r <= eps_pkg::REG_RST[6:0];
            steer_r <= eps_pkg::REG_RST[2:0];
            dbrs_r <= eps_pkg::REG_RST;
            duty_hi_r <= eps_pkg::REG_RST;
            tb_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            shctl_r <= shctl_nxt;
            steer_r <= steer_nxt;
            dbrs_r <= dbrs_nxt;
            duty_hi_r <= duty_hi_nxt;
            tb_r <= tb_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ==========================================================
    // Mode decode, shutdown flag, run gate, steering, duty latch
    always_comb begin
        mode = eps_pkg::EPS_OFF;
        if (ctrl_r[eps_pkg::MODE_HI_LSB +: 2] == eps_pkg::MODE_PWM) begin
            if (ctrl_r[eps_pkg::CFG_LSB +: 2] == eps_pkg::CFG_HALF) begin
                mode = eps_pkg::EPS_HALF; // R1
            end else if (ctrl_r[eps_pkg::CFG_LSB +: 2] == eps_pkg::CFG_SINGLE) begin
                mode = eps_pkg::EPS_SINGLE; // R2
            end
        end
        // Level condition from the selected sources
        cond = (shctl_r[eps_pkg::SRC_LSB + eps_pkg::SRC_FLT_BIT] & ~fault_sync_r) |
               (shctl_r[eps_pkg::SRC_LSB + eps_pkg::SRC_CMP_BIT] & cmp_sync_r); // R6 R9
        if (cond) begin
            flag_nxt = 1'b1; // R7 R9 R10
        end else if (wr_shdn) begin
            flag_nxt = pwdata_in[eps_pkg::SHDN_FLAG_BIT];
        end else if (dbrs_r[eps_pkg::RESTART_BIT]) begin
            flag_nxt = 1'b0; // R12 R13
        end else begin
            flag_nxt = flag_r;
        end
        // Waveform only starts on a fresh period
        run_nxt = (mode != eps_pkg::EPS_OFF) & ~flag_nxt &
                  (run_r | period_start_in); // R11 R23
        if (~steer_r[2] | period_start_in) begin
            steer_eff_nxt = steer_r[1:0]; // R18 R19
        end else begin
            steer_eff_nxt = steer_eff_r;
        end
        duty_buf = {duty_hi_r, ctrl_r[eps_pkg::DUTY_LO_LSB +: 2]};
        duty_act_nxt = period_start_in ? duty_buf : duty_act_r; // R22
        if (period_start_in) begin
            base_nxt = (duty_buf != 10'h000);
        end else if (timebase_count_in == duty_act_r) begin
            base_nxt = 1'b0;
        end else begin
            base_nxt = base_r;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            flag_r <= 1'b0;
            run_r <= 1'b0;
            steer_eff_r <= 2'h0;
            duty_act_r <= 10'h000;
            base_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            run_r <= run_nxt;
            steer_eff_r <= steer_eff_nxt;
            duty_act_r <= duty_act_nxt;
            base_r <= base_nxt;
        end
    end

    // ==========================================================
    // Dead band: per output reload on rise, count instruction ticks
    assign tick = (tick_r == eps_pkg::TICK_LAST);
    always_comb begin
        tick_nxt = tick_r + 2'h1; // R25
        req[0] = base_r;
        req[1] = (mode == eps_pkg::EPS_HALF) ? ~base_r : base_r; // R1
        for (int i = 0; i < 2; i++) begin
            db_cnt_nxt[i] = db_cnt_r[i];
            act_nxt[i] = 1'b0;
            if (mode != eps_pkg::EPS_HALF) begin
                act_nxt[i] = req[i];
            end else if (req[i] & ~req_prev_r[i]) begin
                db_cnt_nxt[i] = dbrs_r[6:0]; // R3 R25
                act_nxt[i] = (dbrs_r[6:0] == 7'h00);
            end else if (req[i]) begin
                if (tick & (db_cnt_r[i] != 7'h00)) begin
                    db_cnt_nxt[i] = db_cnt_r[i] - 7'h01;
                end
                act_nxt[i] = (db_cnt_r[i] == 7'h00); // R5
            end
            // Falling request drops the output at once
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            tick_r <= 2'h0;
            req_prev_r <= 2'h0;
            act_r <= 2'h0;
            db_cnt_r[0] <= 7'h00;
            db_cnt_r[1] <= 7'h00;
        end else begin
            tick_r <= tick_nxt;
            req_prev_r <= req;
            act_r <= act_nxt; // R4
            db_cnt_r[0] <= db_cnt_nxt[0];
            db_cnt_r[1] <= db_cnt_nxt[1];
        end
    end

    // ==========================================================
    // Pin drivers: polarity, steering and shutdown override
    always_comb begin
        logic used;
        logic pol_low;
        logic [1:0] sd;
        used = 1'b0;
        pol_low = 1'b0;
        sd = 2'h0;
        for (int i = 0; i < 2; i++) begin
            unique case (mode)
                eps_pkg::EPS_HALF: used = 1'b1;
                eps_pkg::EPS_SINGLE: used = steer_eff_r[i]; // R14 R15
                eps_pkg::EPS_OFF: used = 1'b0;
            endcase
            pol_low = (i == 0) ? ctrl_r[eps_pkg::POL_A_BIT] : ctrl_r[eps_pkg::POL_B_BIT]; // R16
            sd = (i == 0) ? shctl_r[eps_pkg::PSS_A_LSB +: 2] : shctl_r[eps_pkg::PSS_B_LSB +: 2];
            pin_nxt[i] = 1'b0;
            oe_n_nxt[i] = 1'b1;
            if (used & flag_nxt) begin
                // Forced state on the same edge as the flag, R17 by used
                oe_n_nxt[i] = sd[eps_pkg::SD_TRISTATE_BIT]; // R8 R17
                if (sd == eps_pkg::SD_ACTIVE) begin
                    pin_nxt[i] = ~pol_low; // R24
                end else if (sd == eps_pkg::SD_INACTIVE) begin
                    pin_nxt[i] = pol_low;
                end
            end else if (used) begin
                oe_n_nxt[i] = 1'b0;
                pin_nxt[i] = (run_r & act_r[i]) ^ pol_low;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pin_r <= 2'h0;
            oe_n_r <= 2'h3;
        end else begin
            pin_r <= pin_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    // Outputs straight from flops
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign pwm_out_a_out = pin_r[0];
    assign pwm_out_a_oe_n_out = oe_n_r[0];
    assign pwm_out_b_out = pin_r[1];
    assign pwm_out_b_oe_n_out = oe_n_r[1];
    assign timebase_period_flag_out = tb_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence rise_a_s;
        $rose(req[0]) && (mode == eps_pkg::EPS_HALF) && (dbrs_r[6:0] != 7'h00);
    endsequence
    sequence held_off_s;
        !act_r[0] [*2];
    endsequence

    half_overlap_a: assert property ( // R1
        (mode == eps_pkg::EPS_HALF) |=> !(act_r[0] && act_r[1]))
        else $error("both half-bridge outputs active");
    single_mode_a: assert property ( // R2
        (mode == eps_pkg::EPS_SINGLE) |->
        (ctrl_r[7:6] == 2'h0) && (ctrl_r[3:2] == 2'h3))
        else $error("single mode with wrong control bits");
    dead_delay_a: assert property ( // R3
        rise_a_s |=> held_off_s)
        else $error("dead band did not delay activation");
    deact_fast_a: assert property ( // R4
        $fell(req[0]) |=> !act_r[0])
        else $error("deactivation was delayed");
    flag_set_a: assert property ( // R7
        cond |=> flag_r)
        else $error("condition did not set flag");
    write_ignored_a: assert property ( // R10
        cond && wr_shdn && !pwdata_in[7] |=> flag_r)
        else $error("flag cleared during shutdown");
    auto_clear_a: assert property ( // R12
        dbrs_r[7] && !cond && !wr_shdn |=> !flag_r)
        else $error("auto-restart left flag set");
    steer_off_a: assert property ( // R17
        (mode == eps_pkg::EPS_SINGLE) && !steer_eff_r[1] |=> pwm_out_b_oe_n_out)
        else $error("unsteered pin driven");
    steer_defer_a: assert property ( // R19
        steer_r[2] && !period_start_in |=> $stable(steer_eff_r))
        else $error("synced steering changed mid period");
    duty_hold_a: assert property ( // R22
        !period_start_in |=> $stable(duty_act_r))
        else $error("duty latch changed mid period");
    run_start_a: assert property ( // R23
        $rose(run_r) |-> $past(period_start_in))
        else $error("waveform started mid period");
    tb_flag_a: assert property ( // R21
        period_start_in |=> timebase_period_flag_out)
        else $error("period flag not set");

endmodule // eps_output_stage

//--- verilog/eps_pkg.sv
/*
 * Constants shared by the enhanced PWM output stage: register byte
 * offsets, field positions, reset values and the output mode type.
 * Assumes a 32-bit APB with word-aligned registers in the low byte.
 */
package eps_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SHDN = 8'h04;
    localparam logic [7:0] ADDR_STEER = 8'h08;
    localparam logic [7:0] ADDR_DBRS = 8'h0C;
    localparam logic [7:0] ADDR_DUTY = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // ==========================================================
    // Field positions
    localparam int CFG_LSB = 6;
    localparam int DUTY_LO_LSB = 4;
    localparam int MODE_HI_LSB = 2;
    localparam int POL_A_BIT = 1;
    localparam int POL_B_BIT = 0;
    localparam int SHDN_FLAG_BIT = 7;
    localparam int SRC_LSB = 4;
    localparam int SRC_CMP_BIT = 0;
    localparam int SRC_FLT_BIT = 1;
    localparam int PSS_A_LSB = 2;
    localparam int PSS_B_LSB = 0;
    localparam int STEER_SYNC_BIT = 4;
    localparam int STEER_B_BIT = 1;
    localparam int STEER_A_BIT = 0;
    localparam int RESTART_BIT = 7;
    localparam int STAT_TB_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_COND_BIT = 2;

    // ==========================================================
    // Field codes and reset values
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] MODE_PWM = 2'h3;
    localparam logic [1:0] SD_INACTIVE = 2'h0;
    localparam logic [1:0] SD_ACTIVE = 2'h1;
    localparam int SD_TRISTATE_BIT = 1;
    localparam logic [7:0] REG_RST = 8'h00;

    // ==========================================================
    // Timing: one instruction cycle is four oscillator periods
    localparam int OSC_PER_INSTR = 4;
    localparam logic [1:0] TICK_LAST = 2'(OSC_PER_INSTR - 1);

    typedef enum logic [1:0] {
        EPS_OFF,
        EPS_SINGLE,
        EPS_HALF
    } eps_mode_e;

endpackage
